// ---- design/branch_unit_pkg.sv ----
// package for the conditional branch unit: operation codes, widths, carriers
// assumes a 32-bit core with one branch delay slot
package branch_unit_pkg;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned OFFSET_W      = 16;
  localparam int unsigned LINK_REG_W    = 5;
  localparam logic [4:0]  LINK_REG_IDX  = 5'h1F;
  localparam logic [4:0]  ZERO_REG_IDX  = 5'h00;
  localparam logic [31:0] DELAY_SLOT_INC = 32'h00000004;
  localparam logic [31:0] LINK_INC       = 32'h00000008;
  localparam int unsigned SIGN_BIT      = 31;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_BRANCH_GT_ZERO,
    OP_BRANCH_LT_ZERO,
    OP_BRANCH_LT_ZERO_LINK,
    OP_BRANCH_NOT_EQUAL,
    OP_BRANCH_GE_ZERO_LINK,
    OP_BREAKPOINT
  } branch_op_t;

  // one decoded branch-class instruction from the decode stage
  typedef struct packed {
    logic        valid;
    branch_op_t  op;
    logic [4:0]  src_a_idx;
    logic [31:0] src_a;
    logic [31:0] src_b;
    logic [15:0] offset;
    logic [19:0] code;
    logic [31:0] pc;
  } branch_req_t;

  // link register write toward the general register file
  typedef struct packed {
    logic        wr_en;
    logic [4:0]  wr_idx;
    logic [31:0] wr_data;
  } link_wr_t;

  // redirect and exception requests toward fetch
  typedef struct packed {
    logic        redirect;
    logic [31:0] target;
    logic        breakpoint;
    logic [31:0] epc;
    logic        in_delay_slot;
  } fetch_ctl_t;
endpackage

// ---- design/branch_eval.sv ----
// combinational condition and target evaluation for one branch instruction
// assumes operands are already read from the general register file
`timescale 1ns/10ps
`default_nettype none
module branch_eval (
  input  wire branch_unit_pkg::branch_req_t req,
  output logic                              taken,
  output logic                              links,
  output logic [31:0]                       target,
  output logic [31:0]                       link_addr
);
  import branch_unit_pkg::*;

  logic [31:0] off_ext;
  logic        a_neg;
  logic        a_zero;

  // 16-bit field shifted by one is a 17-bit signed offset
  assign off_ext   = {{(DATA_W - OFFSET_W - 1){req.offset[OFFSET_W-1]}}, req.offset, 1'b0};
  assign target    = req.pc + DELAY_SLOT_INC + off_ext;
  assign link_addr = req.pc + LINK_INC;
  assign a_neg     = req.src_a[SIGN_BIT];
  assign a_zero    = (req.src_a == '0);

  always_comb begin
    taken = 1'b0;
    links = 1'b0;
    case (req.op)
      OP_BRANCH_GT_ZERO:      taken = !a_neg && !a_zero;
      OP_BRANCH_LT_ZERO:      taken = a_neg;
      OP_BRANCH_LT_ZERO_LINK: begin
        taken = a_neg;
        links = 1'b1;
      end
      OP_BRANCH_NOT_EQUAL:    taken = (req.src_a != req.src_b);
      OP_BRANCH_GE_ZERO_LINK: begin
        // register zero reads as zero, so this is the always-taken call form
        taken = !a_neg || (req.src_a_idx == ZERO_REG_IDX);
        links = 1'b1;
      end
      default: begin
        taken = 1'b0;
        links = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// ---- design/conditional_branch_unit.sv ----
// conditional branch unit: resolves branches, writes link, redirects fetch
// assumes decode presents one instruction per issue pulse, in program order
`timescale 1ns/10ps
`default_nettype none
module conditional_branch_unit #(
  parameter int unsigned WORD_W = 32,
  parameter int unsigned IDX_W  = 5
) (
  input  wire logic                        sys_clk,
  input  wire logic                        rst_b,
  input  wire branch_unit_pkg::branch_req_t req,
  input  wire logic                        slot_issue,
  input  wire logic                        slot_exception,
  output branch_unit_pkg::link_wr_t        link_wr,
  output branch_unit_pkg::fetch_ctl_t      fetch_ctl,
  output logic                             slot_pending
);
  import branch_unit_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SLOT
  } state_t;

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks

  // the package carriers fix these sizes, so no other value can be served
  if (WORD_W != DATA_W) begin : g_word_w_check
    $error("word width must equal the carrier width");
  end
  if (IDX_W != LINK_REG_W) begin : g_idx_w_check
    $error("register index width must equal the carrier width");
  end
  if (WORD_W <= OFFSET_W + 1) begin : g_offset_w_check
    $error("word too narrow for the shifted offset");
  end
  if (SIGN_BIT != WORD_W - 1) begin : g_sign_bit_check
    $error("sign bit must be the top bit of the word");
  end
  if (LINK_INC != 2 * DELAY_SLOT_INC) begin : g_link_inc_check
    $error("link value must skip the branch and its slot");
  end

  ////////////////////////////////////////////////////////////////////////////
  // evaluation

  logic              taken;
  logic              links;
  logic [WORD_W-1:0] target;
  logic [WORD_W-1:0] link_addr;

  // condition, target and link value depend on the request alone
  branch_eval branch_eval_inst (
    .req       (req),
    .taken     (taken),
    .links     (links),
    .target    (target),
    .link_addr (link_addr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state

  // the branch address is kept so a faulting slot can restart it
  state_t            state_reg,  state_next;
  logic              taken_reg,  taken_next;
  logic [WORD_W-1:0] target_reg, target_next;
  logic [WORD_W-1:0] br_pc_reg,  br_pc_next;
  link_wr_t          link_reg,   link_next;
  fetch_ctl_t        ctl_reg,    ctl_next;

  ////////////////////////////////////////////////////////////////////////////
  // request decode

  logic slot_open;
  logic accept;
  logic is_trap;
  logic is_branch;
  logic slot_done;
  logic slot_fault;

  assign slot_open  = (state_reg == ST_SLOT);
  // a request while the slot is open is dropped: slots hold no branches
  assign accept     = req.valid && !slot_open;
  assign is_trap    = accept && (req.op == OP_BREAKPOINT);
  assign is_branch  = accept && (req.op != OP_NONE) && (req.op != OP_BREAKPOINT);
  // an exception in the slot wins over a completion in the same cycle
  assign slot_done  = slot_open && (slot_issue || slot_exception);
  assign slot_fault = slot_open && slot_exception;

  ////////////////////////////////////////////////////////////////////////////
  // delay slot tracking

  // one branch in flight; the next is accepted only from the cycle after the slot closes
  always_comb begin
    state_next  = state_reg;
    taken_next  = taken_reg;
    target_next = target_reg;
    br_pc_next  = br_pc_reg;
    case (state_reg)
      ST_IDLE: begin
        if (is_branch) begin
          // condition captured now; the transfer waits for the slot
          taken_next  = taken;
          target_next = target;
          br_pc_next  = req.pc;
          state_next  = ST_SLOT;
        end
      end
      ST_SLOT: begin
        // the slot is never nullified: it completes or faults
        if (slot_done) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_reg  <= ST_IDLE;
      taken_reg  <= 1'h0;
      target_reg <= '0;
      br_pc_reg  <= '0;
    end else begin
      state_reg  <= state_next;
      taken_reg  <= taken_next;
      target_reg <= target_next;
      br_pc_reg  <= br_pc_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link register write

  // a replayed branch writes the same value again, so restart is safe
  always_comb begin
    link_next = '0;
    if (is_branch && links) begin
      // written whether taken or not
      link_next.wr_en   = 1'h1;
      link_next.wr_idx  = LINK_REG_IDX;
      link_next.wr_data = link_addr;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      link_reg <= '0;
    end else begin
      link_reg <= link_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fetch redirect and exceptions

  // every field is zero outside its one-cycle pulse
  always_comb begin
    ctl_next = '0;
    case (state_reg)
      ST_IDLE: begin
        if (is_trap) begin
          // code field never examined; the handler reads the word
          ctl_next.breakpoint = 1'h1;
          ctl_next.epc        = req.pc;
        end
      end
      ST_SLOT: begin
        if (slot_fault) begin
          // restart at the branch so it is evaluated again on return
          ctl_next.epc           = br_pc_reg;
          ctl_next.in_delay_slot = 1'h1;
        end else if (slot_done) begin
          // taken: go after the slot; untaken: fetch continues
          ctl_next.redirect = taken_reg;
          ctl_next.target   = taken_reg ? target_reg : '0;
        end
      end
      default: begin
        ctl_next = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ctl_reg <= '0;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign link_wr      = link_reg;
  assign fetch_ctl    = ctl_reg;
  assign slot_pending = slot_open;
endmodule
`default_nettype wire

// ---- tb/cbu_checker_properties.sv ----
// checker: link, trap and delay-slot timing at the unit's ports
// assumes it is bound to the unit's top module
`timescale 1ns/10ps
`default_nettype none
module cbu_checker (
  input wire logic                         sys_clk,
  input wire logic                         rst_b,
  input wire branch_unit_pkg::branch_req_t req,
  input wire logic                         slot_issue,
  input wire logic                         slot_exception,
  input wire branch_unit_pkg::link_wr_t    link_wr,
  input wire branch_unit_pkg::fetch_ctl_t  fetch_ctl,
  input wire logic                         slot_pending
);
  import branch_unit_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire take = req.valid && !slot_pending;
  wire done = slot_pending && (slot_issue || slot_exception);
  link_write_a: assert property (take && req.op inside {OP_BRANCH_LT_ZERO_LINK, OP_BRANCH_GE_ZERO_LINK}
    |=> link_wr.wr_en && link_wr.wr_idx == 5'h1F && link_wr.wr_data == $past(req.pc) + 32'h8) else $error("link");
  link_cause_a: assert property (link_wr.wr_en |-> $past(take)) else $error("stray link");
  trap_now_a: assert property (take && req.op == OP_BREAKPOINT
    |=> fetch_ctl.breakpoint && fetch_ctl.epc == $past(req.pc) && !slot_pending) else $error("trap");
  slot_wait_a: assert property (take && !(req.op inside {OP_NONE, OP_BREAKPOINT}) |=> slot_pending)
    else $error("no slot wait");
  slot_hold_a: assert property (slot_pending && !done |=> slot_pending) else $error("slot dropped");
  slot_end_a: assert property (done |=> !slot_pending) else $error("slot stuck");
  redirect_cause_a: assert property (fetch_ctl.redirect |-> $past(done && !slot_exception)) else $error("redirect");
  slot_fault_a: assert property (done && slot_exception |=> fetch_ctl.in_delay_slot && !fetch_ctl.redirect)
    else $error("slot fault");
endmodule
`default_nettype wire

// ---- tb/branch_slot_model.sv ----
// partner: fetch/decode finishing the delay-slot instruction
// assumes slot_pending marks a branch awaiting its slot
`timescale 1ns/10ps
`default_nettype none
module branch_slot_model (
  input  wire logic       sys_clk,
  input  wire logic       slot_pending,
  input  wire logic       fail,
  input  wire logic [1:0] lat,
  output var logic        slot_issue,
  output var logic        slot_exception
);
  logic [1:0] n = 2'h0;
  always @(negedge sys_clk) begin
    {slot_issue, slot_exception} <= 2'h0;
    n <= 2'h0;
    // slot holds one 32-bit non-branch instruction only
    if (slot_pending && !slot_issue && !slot_exception) begin
      n <= n + 2'h1;
      if (n == lat) {slot_issue, slot_exception} <= {!fail, fail};
    end
  end
endmodule
`default_nettype wire

// ---- tb/test_conditional_branch_unit.sv ----
// bench: branch unit against the slot model
// assumes 100 MHz clock, inputs driven on the falling edge
`timescale 1ns/10ps
`default_nettype none
module test_conditional_branch_unit;
  import branch_unit_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_b   = 1'b0;
  logic        fail    = 1'b0;
  branch_req_t req     = '0;
  logic [31:0] pc      = 32'h0;
  logic        slot_issue, slot_exception, slot_pending;
  link_wr_t    link_wr;
  fetch_ctl_t  fetch_ctl;
  int          mismatches = 0, cmp_count = 0, cyc = 0;
  always #5 sys_clk = ~sys_clk;
  conditional_branch_unit conditional_branch_unit_inst (.*);
  // slot latency follows pc so prompt and slow answers both occur
  branch_slot_model branch_slot_model_inst (.lat(pc[9:8]), .*);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // never names register 31 as a linking source
  task automatic br(input branch_op_t op, input logic [31:0] a, b, input logic [4:0] idx, input logic tk);
    logic [15:0] off;
    pc = pc + 32'h104;
    off = {pc[8], pc[14:0]};
    req = '{1'b1, op, idx, a, b, off, 20'hFFFFF, pc};
    @(negedge sys_clk);
    req.valid = 1'b0;
    chk(link_wr.wr_en, op inside {OP_BRANCH_LT_ZERO_LINK, OP_BRANCH_GE_ZERO_LINK});
    if (link_wr.wr_en) chk(link_wr.wr_data, pc + 32'h8);
    if (link_wr.wr_en) chk(link_wr.wr_idx, 5'h1F);
    while (slot_pending) @(negedge sys_clk);
    chk(fetch_ctl.redirect, tk && !fail);
    if (tk && !fail) chk(fetch_ctl.target, pc + 32'h4 + {{15{off[15]}}, off, 1'b0});
    if (fail) chk(fetch_ctl.epc, pc);
    chk(fetch_ctl.in_delay_slot, fail);
  endtask
  task automatic t_cond;
    br(OP_BRANCH_GT_ZERO, 32'h1, 32'h0, 5'h4, 1'b1);
    br(OP_BRANCH_GT_ZERO, 32'h0, 32'h0, 5'h4, 1'b0);
    br(OP_BRANCH_GT_ZERO, 32'h80000000, 32'h0, 5'h4, 1'b0);
    br(OP_BRANCH_LT_ZERO, 32'h80000000, 32'h0, 5'h4, 1'b1);
    br(OP_BRANCH_LT_ZERO_LINK, 32'hFFFFFFFF, 32'h0, 5'h4, 1'b1);
    br(OP_BRANCH_LT_ZERO_LINK, 32'h7FFFFFFF, 32'h0, 5'h4, 1'b0);
    br(OP_BRANCH_NOT_EQUAL, 32'h5, 32'h5, 5'h4, 1'b0);
    br(OP_BRANCH_NOT_EQUAL, 32'h5, 32'h4, 5'h4, 1'b1);
    br(OP_BRANCH_GE_ZERO_LINK, 32'h0, 32'h0, 5'h4, 1'b1);
    br(OP_BRANCH_GE_ZERO_LINK, 32'h80000000, 32'h0, 5'h4, 1'b0);
    br(OP_BRANCH_GE_ZERO_LINK, 32'h80000000, 32'h0, 5'h0, 1'b1);
    $display("test cond done");
  endtask
  task automatic t_exc;
    fail = 1'b1;
    br(OP_BRANCH_LT_ZERO_LINK, 32'h80000000, 32'h0, 5'h4, 1'b1);
    fail = 1'b0;
    $display("test exc done");
  endtask
  task automatic t_brk;
    req = '{1'b1, OP_BREAKPOINT, 5'h0, 32'h0, 32'h0, 16'h0, 20'h5A5A5, 32'h40};
    @(negedge sys_clk);
    req.valid = 1'b0;
    chk(fetch_ctl.breakpoint, 1'b1);
    chk(fetch_ctl.epc, 32'h40);
    @(negedge sys_clk);
    $display("test brk done");
  endtask
  initial begin
    repeat (2) @(negedge sys_clk);
    rst_b = 1'b1;
    t_cond;
    t_brk;
    t_exc;
    results;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      results;
    end
  end
endmodule
bind conditional_branch_unit cbu_checker cbu_checker_inst (.*);
`default_nettype wire
